// *** inc/fsr_if.sv ***
`timescale 1ns/10ps

interface fsr_if;
  logic       sclk;
  logic       csN;
  logic       si;
  logic       so;
  logic       soOe;
  logic       soLine;
  logic       ifSel;
  logic [7:0] hostBus;
  logic       hostBusOe;
  logic [7:0] devBus;
  logic       devBusOe;
  logic [7:0] bus;

  // Undriven lines read as pulled high
  assign bus    = hostBusOe ? hostBus : (devBusOe ? devBus : 8'hFF);
  assign soLine = soOe ? so : 1'b1;

  modport dev (
    input  sclk,
    input  csN,
    input  si,
    input  ifSel,
    input  bus,
    output so,
    output soOe,
    output devBus,
    output devBusOe
  );

  modport host (
    input  soLine,
    input  bus,
    output sclk,
    output csN,
    output si,
    output ifSel,
    output hostBus,
    output hostBusOe
  );
endinterface

// *** inc/fsr_params.svh ***
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

`define FSR_OPC_STREAM_POL 8'h68
`define FSR_OPC_STREAM_SPI 8'hE8
`define FSR_PAGE_W         13
`define FSR_OFF_W          11
`define FSR_BUF_OFF_W      11
`define FSR_LAST_PAGE      13'h1FFF
`define FSR_LAST_OFF       11'h41F
`define FSR_ADDR_BYTES     3
`define FSR_DUMMY_SER      4
`define FSR_DUMMY_PAR      60
`define FSR_DUMMY_LAST_SER 6'(`FSR_DUMMY_SER - 1)
`define FSR_DUMMY_LAST_PAR 6'(`FSR_DUMMY_PAR - 1)
`define FSR_TX_LAST_SER    6'((8 * (1 + `FSR_ADDR_BYTES + `FSR_DUMMY_SER)) - 1)
`define FSR_TX_LAST_PAR    6'((1 + `FSR_ADDR_BYTES + `FSR_DUMMY_PAR) - 1)
`define FSR_CLK_PERIOD_PS  5000
`define FSR_SCLK_PERIOD_NS 200
`define FSR_SCLK_HALF_CYC  8'(((`FSR_SCLK_PERIOD_NS * 500) + `FSR_CLK_PERIOD_PS - 1) / `FSR_CLK_PERIOD_PS)

`endif

// *** inc/fsr_pkg.sv ***
`include "fsr_params.svh"

package fsr_pkg;

  typedef logic [`FSR_PAGE_W-1:0]    fsr_page_t;
  typedef logic [`FSR_OFF_W-1:0]     fsr_off_t;
  typedef logic [`FSR_BUF_OFF_W-1:0] fsr_buf_off_t;

  typedef enum logic [4:0] {
    DEV_OPCODE = 5'b00001,
    DEV_ADDR   = 5'b00010,
    DEV_DUMMY  = 5'b00100,
    DEV_STREAM = 5'b01000,
    DEV_IGNORE = 5'b10000
  } fsr_dev_state_e;

  typedef enum logic [4:0] {
    HST_IDLE = 5'b00001,
    HST_LEAD = 5'b00010,
    HST_LOW  = 5'b00100,
    HST_HIGH = 5'b01000,
    HST_TAIL = 5'b10000
  } fsr_hst_state_e;

  typedef struct packed {
    fsr_dev_state_e st;
    logic [2:0]     bitCnt;
    logic [5:0]     byteCnt;
    logic [7:0]     shift;
    logic [15:0]    addrHi;
    logic           parMode;
    logic           spiMode;
    fsr_page_t      page;
    fsr_off_t       off;
    logic [7:0]     txByte;
    logic           so;
    logic           soOe;
    logic [7:0]     busOut;
    logic           busOe;
    logic           active;
  } fsr_dev_s;

  typedef struct packed {
    fsr_hst_state_e st;
    logic [7:0]     div;
    logic           csN;
    logic           sclk;
    logic           si;
    logic [7:0]     busOut;
    logic           busOe;
    logic           parMode;
    logic           idleHigh;
    logic [7:0]     opc;
    logic [23:0]    addr;
    logic [5:0]     cnt;
    logic           reading;
    logic [7:0]     rxShift;
    logic [2:0]     rxBits;
    logic [7:0]     rdData;
    logic           rdValid;
    logic           stopReq;
    logic           busy;
  } fsr_hst_s;

  function automatic logic fsr_is_stream(input logic [7:0] opc);
    return (opc == `FSR_OPC_STREAM_POL) || (opc == `FSR_OPC_STREAM_SPI);
  endfunction

  // Page step and array wrap both happen here, so no dead cycles appear
  function automatic logic [23:0] fsr_next_loc(input fsr_page_t page, input fsr_off_t off);
    if (off == `FSR_LAST_OFF) begin
      if (page == `FSR_LAST_PAGE) begin
        return 24'h000000;
      end
      return {page + 13'h0001, 11'h000};
    end
    return {page, off + 11'h001};
  endfunction

  function automatic logic [7:0] fsr_tx_byte(input logic [5:0] idx, input logic [7:0] opc, input logic [23:0] addr);
    case (idx)
      6'h00:   return opc;
      6'h01:   return addr[23:16];
      6'h02:   return addr[15:8];
      6'h03:   return addr[7:0];
      default: return 8'h00;
    endcase
  endfunction

endpackage

// *** src/fsr_device.sv ***
`timescale 1ns/10ps
`include "fsr_params.svh"

// Functional notes
// - Select fall starts, opcode then address
// - Each clock shifts in serial or parallel
// - Everything moves most significant bit first
// - One shared clock input for both interfaces
// - Array is 8192 pages of 1056 bytes
// - Buffer offset is an 11-bit field
// - Location is 13-bit page, 11-bit offset
// - Opcode variant sets spiModeSel, one of two modes
// - Opcodes 68H or E8H plus three address bytes
// - Host sends 4 serial or 60 parallel dummies
// - First 13 bits page, last 11 offset
// - After dummies every clock outputs data
// - Read address advances with every byte output
// - Host keeps select low whole transaction
// - Page end continues next page, no delay
// - Array end wraps to page zero, no delay
// - Select rise ends read, releases outputs
// - Stream read never touches data buffers
// - Host clock within maximum stream frequency
module fsr_device
  import fsr_pkg::*;
(
  fsr_if.dev          link,
  input  logic        rst_b,
  input  logic        clkEn,
  input  logic [7:0]  arrayData,
  output logic [23:0] arrayAddr,
  output logic        streaming,
  output logic        spiModeSel
);

  fsr_dev_s     state_reg;
  fsr_dev_s     state_next;
  fsr_buf_off_t bufOffUnused;
  logic         ifSelSync;
  logic         frameRst;
  logic         firstEdge;
  logic         curPar;
  logic [7:0]   rxByte;
  logic         byteDone;
  logic [5:0]   dummyLast;
  logic [23:0]  startLoc;
  logic [23:0]  nextLoc;

  // The stream path has no buffer port at all; this offset type exists only for the buffer field width
  assign bufOffUnused = '0;

  fsr_sync #(
    .WIDTH (1)
  ) ifSelSyncU (
    .clk   (link.sclk),
    .rst_b (rst_b),
    .clkEn (clkEn),
    .din   (link.ifSel),
    .dout  (ifSelSync)
  );

  // Select high holds the whole sequencer idle, so its fall starts a fresh opcode
  assign frameRst = !rst_b || link.csN;

  assign firstEdge = (state_reg.st == DEV_OPCODE) && (state_reg.bitCnt == 3'h0);
  // Mode is fixed at the first edge of a frame and held until select rises
  assign curPar    = firstEdge ? ifSelSync : state_reg.parMode;
  assign rxByte    = curPar ? link.bus : {state_reg.shift[6:0], link.si};
  assign byteDone  = curPar || (state_reg.bitCnt == 3'h7);
  assign dummyLast = curPar ? `FSR_DUMMY_LAST_PAR : `FSR_DUMMY_LAST_SER;
  assign startLoc  = {state_reg.addrHi, rxByte};
  assign nextLoc   = fsr_next_loc(state_reg.page, state_reg.off);

  always_comb begin
    logic emit;
    emit       = 1'b0;
    state_next = state_reg;
    if (clkEn) begin
      state_next.parMode = curPar;
      if (!curPar) begin
        state_next.shift  = rxByte;
        state_next.bitCnt = state_reg.bitCnt + 3'h1;
      end
      case (state_reg.st)
        DEV_OPCODE: begin
          if (byteDone) begin
            state_next.spiMode = (rxByte == `FSR_OPC_STREAM_SPI);
            state_next.byteCnt = 6'h00;
            state_next.st      = fsr_is_stream(rxByte) ? DEV_ADDR : DEV_IGNORE;
          end
        end
        DEV_ADDR: begin
          if (byteDone) begin
            if (state_reg.byteCnt == 6'(`FSR_ADDR_BYTES - 1)) begin
              state_next.page    = startLoc[23:`FSR_OFF_W];
              state_next.off     = startLoc[`FSR_OFF_W-1:0];
              state_next.byteCnt = 6'h00;
              state_next.st      = DEV_DUMMY;
            end else begin
              state_next.addrHi  = {state_reg.addrHi[7:0], rxByte};
              state_next.byteCnt = state_reg.byteCnt + 6'h01;
            end
          end
        end
        DEV_DUMMY: begin
          if (byteDone) begin
            if (state_reg.byteCnt == dummyLast) begin
              // First data leaves on the edge that takes the last dummy
              emit          = 1'b1;
              state_next.st = DEV_STREAM;
            end else begin
              state_next.byteCnt = state_reg.byteCnt + 6'h01;
            end
          end
        end
        DEV_STREAM: begin
          emit = 1'b1;
        end
        DEV_IGNORE: begin
          // Unsupported opcodes are clocked through silently until select rises
          state_next.st = DEV_IGNORE;
        end
        default: begin
          state_next.st = DEV_IGNORE;
        end
      endcase
      if (emit) begin
        state_next.active = 1'b1;
        if (curPar) begin
          state_next.busOut = arrayData;
          state_next.busOe  = 1'b1;
          {state_next.page, state_next.off} = nextLoc;
        end else begin
          state_next.soOe = 1'b1;
          if (byteDone) begin
            state_next.so     = arrayData[7];
            state_next.txByte = {arrayData[6:0], 1'b0};
            {state_next.page, state_next.off} = nextLoc;
          end else begin
            state_next.so     = state_reg.txByte[7];
            state_next.txByte = {state_reg.txByte[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Everything runs on the shared link clock, whichever interface carries the frame
  always_ff @(posedge link.sclk or posedge frameRst) begin
    if (frameRst) begin
      state_reg         <= '0;
      state_reg.st      <= DEV_OPCODE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.so       = state_reg.so;
  assign link.soOe     = state_reg.soOe;
  assign link.devBus   = state_reg.busOut;
  assign link.devBusOe = state_reg.busOe;
  assign arrayAddr     = {state_reg.page, state_reg.off};
  assign streaming     = state_reg.active;
  assign spiModeSel    = state_reg.spiMode;
endmodule // fsr_device

// *** src/fsr_host.sv ***
`timescale 1ns/10ps
`include "fsr_params.svh"

module fsr_host
  import fsr_pkg::*;
(
  input  logic        clk,
  input  logic        rst_b,
  input  logic        clkEn,
  fsr_if.host         link,
  input  logic        start,
  input  logic        useSpiOpcode,
  input  logic [23:0] startAddr,
  input  logic        parMode,
  input  logic        clkIdleHigh,
  input  logic        stop,
  output logic [7:0]  rdData,
  output logic        rdValid,
  output logic        busy
);

  fsr_hst_s    state_reg;
  fsr_hst_s    state_next;
  logic [8:0]  rxSync;
  logic        tick;
  logic [5:0]  txLast;
  logic [7:0]  opcSel;
  logic [7:0]  firstByte;
  logic [7:0]  nextByte;

  fsr_sync #(
    .WIDTH (9)
  ) rxSyncU (
    .clk   (clk),
    .rst_b (rst_b),
    .clkEn (clkEn),
    .din   ({link.soLine, link.bus}),
    .dout  (rxSync)
  );

  // Half period rounded up keeps the link clock at or below its ceiling
  assign tick      = (state_reg.div == (`FSR_SCLK_HALF_CYC - 8'h01));
  assign txLast    = state_reg.parMode ? `FSR_TX_LAST_PAR : `FSR_TX_LAST_SER;
  assign opcSel    = useSpiOpcode ? `FSR_OPC_STREAM_SPI : `FSR_OPC_STREAM_POL;
  assign firstByte = fsr_tx_byte(6'h00, opcSel, startAddr);
  assign nextByte  = fsr_tx_byte(state_reg.parMode ? state_reg.cnt : {3'h0, state_reg.cnt[5:3]},
                                 state_reg.opc, state_reg.addr);

  always_comb begin
    state_next = state_reg;
    if (clkEn) begin
      state_next.rdValid = 1'b0;
      state_next.div     = tick ? 8'h00 : state_reg.div + 8'h01;
      if (stop && state_reg.busy) begin
        state_next.stopReq = 1'b1;
      end
      case (state_reg.st)
        HST_IDLE: begin
          state_next.div = 8'h00;
          if (start) begin
            // Select falls one half later, so a change of idle level never makes a counted edge
            state_next.st       = HST_LEAD;
            state_next.busy     = 1'b1;
            state_next.stopReq  = 1'b0;
            state_next.opc      = opcSel;
            state_next.addr     = startAddr;
            state_next.parMode  = parMode;
            state_next.idleHigh = clkIdleHigh;
            state_next.sclk     = clkIdleHigh;
            state_next.cnt      = 6'h00;
            state_next.reading  = 1'b0;
            state_next.rxBits   = 3'h0;
            state_next.si       = firstByte[7];
            state_next.busOut   = firstByte;
            state_next.busOe    = parMode;
          end
        end
        HST_LEAD: begin
          if (tick) begin
            if (state_reg.csN) begin
              state_next.csN = 1'b0;
            end else begin
              state_next.st   = HST_LOW;
              state_next.sclk = 1'b0;
            end
          end
        end
        HST_LOW: begin
          if (tick) begin
            state_next.st   = HST_HIGH;
            state_next.sclk = 1'b1;
            if (state_reg.reading) begin
              if (state_reg.parMode) begin
                state_next.rdData  = rxSync[7:0];
                state_next.rdValid = 1'b1;
              end else begin
                state_next.rxShift = {state_reg.rxShift[6:0], rxSync[8]};
                state_next.rxBits  = state_reg.rxBits + 3'h1;
                if (state_reg.rxBits == 3'h7) begin
                  state_next.rdData  = {state_reg.rxShift[6:0], rxSync[8]};
                  state_next.rdValid = 1'b1;
                end
              end
            end else if (state_reg.cnt == txLast) begin
              // Release the bus on the edge where the device starts driving
              state_next.reading = 1'b1;
              state_next.busOe   = 1'b0;
            end else begin
              state_next.cnt = state_reg.cnt + 6'h01;
            end
          end
        end
        HST_HIGH: begin
          if (tick) begin
            // Select stays low until reading has begun and no serial byte is half read
            if (state_reg.stopReq && state_reg.reading && (state_reg.parMode || state_reg.rxBits == 3'h0)) begin
              state_next.st   = HST_TAIL;
              state_next.sclk = state_reg.idleHigh;
            end else begin
              state_next.st   = HST_LOW;
              state_next.sclk = 1'b0;
              if (!state_reg.reading) begin
                state_next.si     = nextByte[3'h7 - state_reg.cnt[2:0]];
                state_next.busOut = nextByte;
              end
            end
          end
        end
        HST_TAIL: begin
          if (tick) begin
            state_next.st      = HST_IDLE;
            state_next.csN     = 1'b1;
            state_next.busy    = 1'b0;
            state_next.stopReq = 1'b0;
          end
        end
        default: begin
          state_next.st = HST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= '0;
      state_reg.st  <= HST_IDLE;
      state_reg.csN <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.sclk      = state_reg.sclk;
  assign link.csN       = state_reg.csN;
  assign link.si        = state_reg.si;
  assign link.ifSel     = state_reg.parMode;
  assign link.hostBus   = state_reg.busOut;
  assign link.hostBusOe = state_reg.busOe;
  assign rdData         = state_reg.rdData;
  assign rdValid        = state_reg.rdValid;
  assign busy           = state_reg.busy;
endmodule // fsr_host

// *** src/fsr_sync.sv ***
`timescale 1ns/10ps

module fsr_sync #(
  parameter int WIDTH = 1
) (
  input  logic             clk,
  input  logic             rst_b,
  input  logic             clkEn,
  input  logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } fsr_sync_s;

  fsr_sync_s state_reg;
  fsr_sync_s state_next;

  always_comb begin
    state_next = state_reg;
    if (clkEn) begin
      state_next.meta = din;
      state_next.sync = state_reg.meta;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dout = state_reg.sync;
endmodule // fsr_sync

// *** verif/flash_cmd_front_end_stream_read_tb.sv ***
`timescale 1ns/10ps

module flash_cmd_front_end_stream_read_tb;
  logic        clk;
  logic        rst_b;
  logic        start;
  logic        useSpiOpcode;
  logic [23:0] startAddr;
  logic        parMode;
  logic        clkIdleHigh;
  logic        stop;
  logic [7:0]  rdData;
  logic        rdValid;
  logic        busy;
  logic [23:0] arrayAddr;
  logic        streaming;
  logic        spiModeSel;
  logic [7:0]  wireOpc;
  int          wireEdges;
  int          n_mismatch;
  int          checked;

  // Content mixes page and offset bits, so a wrong address split shows
  function automatic logic [7:0] memByte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction

  function automatic logic [23:0] nextLoc(input logic [23:0] a);
    if (a[10:0] != 11'h41F) return a + 24'h000001;
    if (a[23:11] == 13'h1FFF) return 24'h000000;
    return {a[23:11] + 13'h0001, 11'h000};
  endfunction

  fsr_if link ();
  fsr_host i_fsr_host (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .link(link), .start(start),
    .useSpiOpcode(useSpiOpcode), .startAddr(startAddr), .parMode(parMode), .clkIdleHigh(clkIdleHigh),
    .stop(stop), .rdData(rdData), .rdValid(rdValid), .busy(busy));
  fsr_device i_fsr_device (.link(link), .rst_b(rst_b), .clkEn(1'b1), .arrayData(memByte(arrayAddr)),
    .arrayAddr(arrayAddr), .streaming(streaming), .spiModeSel(spiModeSel));
  fsr_link_asserts i_fsr_link_asserts (.clk(clk), .rst_b(rst_b), .sclk(link.sclk), .csN(link.csN),
    .si(link.si), .ifSel(link.ifSel), .bus(link.bus), .soOe(link.soOe), .devBusOe(link.devBusOe));

  always #2.5 clk = ~clk;

  // Independent view of the wire: opcode bits and link clock count per frame
  always @(negedge link.csN) wireEdges = 0;
  always @(posedge link.sclk) begin
    if (!link.csN) begin
      if (wireEdges == 0 && link.ifSel) wireOpc = link.bus;
      else if (wireEdges < 8 && !link.ifSel) wireOpc = {wireOpc[6:0], link.si};
      wireEdges = wireEdges + 1;
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wait_until(input logic wantValid);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((wantValid ? rdValid !== 1'b1 : busy !== 1'b0) && n < 4000);
    if (n >= 4000) begin
      n_mismatch++;
      test_done();
    end
  endtask

  // One whole frame; stop given at once or after nBytes checked bytes
  task automatic run_frame(input logic spi, par, idleH, input logic [23:0] addr, input int nBytes,
                           input logic early);
    logic [23:0] loc;
    loc = addr;
    @(posedge clk);
    useSpiOpcode <= spi;
    parMode      <= par;
    clkIdleHigh  <= idleH;
    startAddr    <= addr;
    start        <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    stop  <= early;
    @(posedge clk);
    stop <= 1'b0;
    for (int i = 0; i < nBytes; i++) begin
      wait_until(1'b1);
      chk(rdData, memByte(loc));
      if (i == 0) chk({streaming, spiModeSel}, {1'b1, spi});
      loc = nextLoc(loc);
    end
    if (!early) begin
      stop <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
    end
    wait_until(1'b0);
    @(posedge clk);
    chk({link.soOe, link.devBusOe, streaming}, 3'b000);
    chk(link.sclk, idleH);
    chk(wireOpc, spi ? 8'hE8 : 8'h68);
    chk(wireEdges >= 64, 1'b1);
  endtask

  task automatic test_serial_page_cross();
    run_frame(1'b0, 1'b0, 1'b0, {13'h0005, 11'h41E}, 4, 1'b0);
    $display("test_serial_page_cross done");
  endtask

  task automatic test_early_stop();
    // A stop pulsed right after start ends the frame before any byte is read back
    run_frame(1'b0, 1'b0, 1'b0, {13'h0ABC, 11'h123}, 0, 1'b1);
    $display("test_early_stop done");
  endtask

  task automatic test_serial_array_wrap();
    run_frame(1'b1, 1'b0, 1'b1, {13'h1FFF, 11'h41E}, 3, 1'b0);
    $display("test_serial_array_wrap done");
  endtask

  // Device adopts a new interface select only after a frame under it
  task automatic test_mode_switch();
    run_frame(1'b1, 1'b1, 1'b1, {13'h0001, 11'h000}, 0, 1'b1);
    $display("test_mode_switch done");
  endtask

  task automatic test_parallel_array_wrap();
    run_frame(1'b1, 1'b1, 1'b1, {13'h1FFF, 11'h41F}, 3, 1'b0);
    $display("test_parallel_array_wrap done");
  endtask

  task automatic test_parallel_page_cross();
    run_frame(1'b0, 1'b1, 1'b0, {13'h1234, 11'h41F}, 2, 1'b0);
    $display("test_parallel_page_cross done");
  endtask

  initial begin
    clk          = 1'b0;
    rst_b        = 1'b0;
    start        = 1'b0;
    stop         = 1'b0;
    useSpiOpcode = 1'b0;
    startAddr    = 24'h000000;
    parMode      = 1'b0;
    clkIdleHigh  = 1'b0;
    wireOpc      = 8'h00;
    wireEdges    = 0;
    n_mismatch   = 0;
    checked      = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    test_serial_page_cross();
    test_early_stop();
    test_serial_array_wrap();
    test_mode_switch();
    test_parallel_array_wrap();
    test_parallel_page_cross();
    test_done();
  end
endmodule // flash_cmd_front_end_stream_read_tb

// *** verif/fsr_link_asserts.sv ***
`timescale 1ns/10ps
`include "fsr_params.svh"

module fsr_link_asserts (
  input logic       clk,
  input logic       rst_b,
  input logic       sclk,
  input logic       csN,
  input logic       si,
  input logic       ifSel,
  input logic [7:0] bus,
  input logic       soOe,
  input logic       devBusOe
);
  logic [6:0] edgeCnt;
  logic [7:0] opc;
  logic       lastSel;
  logic       frameOk;
  logic       opcOk;
  logic       valid;

  assign opcOk = (opc == `FSR_OPC_STREAM_POL) || (opc == `FSR_OPC_STREAM_SPI);
  assign valid = frameOk && opcOk;

  // Cleared by select high, just as the device state is
  always_ff @(posedge sclk or posedge csN or negedge rst_b) begin
    if (!rst_b || csN) begin
      edgeCnt <= 7'h00;
    end else if (edgeCnt != 7'h7F) begin
      edgeCnt <= edgeCnt + 7'h01;
    end
  end

  // First frame after a mode change is not judged: the device synchroniser lags
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      lastSel <= 1'b0;
      frameOk <= 1'b0;
      opc     <= 8'h00;
    end else begin
      lastSel <= ifSel;
      if (edgeCnt == 7'h00) begin
        frameOk <= (lastSel == ifSel);
      end
      if (edgeCnt == 7'h00 && ifSel) begin
        opc <= bus;
      end else if (edgeCnt < 7'h08 && !ifSel) begin
        opc <= {opc[6:0], si};
      end
    end
  end

  AST_PRIME_QUIET: assert property (@(posedge sclk) disable iff (!rst_b || csN)
    edgeCnt < 7'h40 |-> !soOe && !devBusOe) else $error("output driven before dummies done");
  AST_DATA_STARTS: assert property (@(posedge sclk) disable iff (!rst_b || csN)
    valid && edgeCnt == 7'h40 |-> (ifSel ? devBusOe && !soOe : soOe && !devBusOe))
    else $error("data did not start after dummies");
  AST_DATA_HOLDS: assert property (@(posedge sclk) disable iff (!rst_b || csN)
    valid && edgeCnt > 7'h40 |-> (ifSel ? devBusOe : soOe)) else $error("stream output dropped");
  AST_SER_NO_BUS: assert property (@(posedge sclk) disable iff (!rst_b || csN)
    valid && !ifSel |-> !devBusOe) else $error("parallel bus driven in serial mode");
  AST_PAR_NO_SO: assert property (@(posedge sclk) disable iff (!rst_b || csN)
    valid && ifSel |-> !soOe) else $error("serial out driven in parallel mode");
  AST_HOST_OPCODE: assert property (@(posedge sclk) disable iff (!rst_b || csN)
    frameOk && edgeCnt == 7'h08 |-> opcOk) else $error("host sent unknown opcode");
  AST_IDLE_RELEASED: assert property (@(posedge clk) disable iff (!rst_b)
    csN |-> !soOe && !devBusOe) else $error("output driven while deselected");
  // The idle level may be set once within 22 clocks of select rising, while select is still high
  AST_IDLE_CLK_STILL: assert property (@(posedge clk) disable iff (!rst_b)
    csN && $past(csN) && $past(csN, 22) |-> $stable(sclk)) else $error("link clock moved outside frame");
  AST_END_CLK_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(csN) |-> $past(sclk) == $past(sclk, 19)) else $error("select rose with clock moving");

  COV_SER_STREAM: cover property (@(posedge sclk) valid && !ifSel && edgeCnt == 7'h41);
  COV_PAR_STREAM: cover property (@(posedge sclk) valid && ifSel && edgeCnt == 7'h41);
  COV_SPI_OPC: cover property (@(posedge sclk) edgeCnt == 7'h08 && opc == `FSR_OPC_STREAM_SPI);
endmodule // fsr_link_asserts
